// ### hw/sto_filt_if.sv
// Carrier between the axis logic and the input filter: raw pins and clean levels.
// Assumes both ends run on the same system clock.
`timescale 1ns/100ps
interface sto_filt_if;
  logic [sto_pkg::N_IN-1:0] raw;
  logic [sto_pkg::N_IN-1:0] clean;
  modport filt (input raw, output clean);
  modport core (output raw, input clean);
endinterface

// ### hw/sto_in_filter.sv
// Three-stage synchroniser and debounce filter for every pin input of the unit.
// Assumes raw levels arrive asynchronously; a change needs stages two and three
// to agree and then to hold for the debounce count.
`timescale 1ns/100ps
module sto_in_filter #(
  parameter logic [sto_pkg::DEB_W-1:0] DEB_CYC = sto_pkg::DEB_W'(sto_pkg::DEB_MS * sto_pkg::CYC_PER_MS)
) (
  input  wire logic i_sys_clk,   // System clock.
  input  wire logic i_rst_n,     // Asynchronous reset, active low.
  sto_filt_if.filt  f            // Raw in, clean out.
);

  logic [sto_pkg::N_IN-1:0]  s1_q;
  logic [sto_pkg::N_IN-1:0]  s2_q;
  logic [sto_pkg::N_IN-1:0]  s3_q;
  logic [sto_pkg::N_IN-1:0]  clean_q;
  logic [sto_pkg::DEB_W-1:0] cnt_q [sto_pkg::N_IN];

  // Reset to open contacts so every axis starts in the torque-off state.
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      s1_q <= f.raw;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      clean_q <= '0;
      for (int i = 0; i < sto_pkg::N_IN; i++) begin
        cnt_q[i] <= '0;
      end
    end else begin
      for (int i = 0; i < sto_pkg::N_IN; i++) begin
        if (s2_q[i] != s3_q[i] || s3_q[i] == clean_q[i]) begin
          cnt_q[i] <= '0;
        end else if (cnt_q[i] == DEB_CYC - 1'b1) begin
          cnt_q[i]   <= '0;
          clean_q[i] <= s3_q[i];
        end else begin
          cnt_q[i] <= cnt_q[i] + 1'b1;
        end
      end
    end
  end

  assign f.clean = clean_q;

endmodule

// ### hw/sto_pkg.sv
// Constants, timing figures and state types of the two-axis torque-off unit.
// Assumes a single 125 MHz system clock; every time below is converted from it.
package sto_pkg;

  // System clock period and the cycles that make one millisecond.
  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam logic [31:0] CYC_PER_MS    = 32'(1_000_000 / CLK_PERIOD_NS);

  // Selectable stop delays in milliseconds.
  localparam logic [31:0] DLY_1P4_MS  = 32'd1400;
  localparam logic [31:0] DLY_2P8_MS  = 32'd2800;
  localparam logic [31:0] DLY_5P6_MS  = 32'd5600;
  localparam logic [31:0] DLY_9P8_MS  = 32'd9800;
  localparam logic [31:0] DLY_30P8_MS = 32'd30800;

  // Worst-case response with zero delay, input off to outputs open.
  localparam logic [31:0] RESP_MAX_MS = 32'd10;
  // Input debounce time, well inside the response budget.
  localparam logic [31:0] DEB_MS      = 32'd1;
  // How long the two shutdown channels of one axis may disagree.
  localparam logic [31:0] DISC_MS     = 32'd100;

  localparam int DEB_W = 20;
  localparam int CNT_W = 32;

  // Delay switch codes.
  localparam logic [2:0] SEL_0S   = 3'h0;
  localparam logic [2:0] SEL_1P4  = 3'h1;
  localparam logic [2:0] SEL_2P8  = 3'h2;
  localparam logic [2:0] SEL_5P6  = 3'h3;
  localparam logic [2:0] SEL_9P8  = 3'h4;
  localparam logic [2:0] SEL_30P8 = 3'h5;

  // Input vector layout: seven bits per axis, axis A first.
  localparam int N_AXIS      = 2;
  localparam int IN_PER_AXIS = 7;
  localparam int N_IN        = N_AXIS * IN_PER_AXIS;
  localparam int IN_SD1      = 0;
  localparam int IN_SD2      = 1;
  localparam int IN_REL      = 2;
  localparam int IN_FB       = 3;
  localparam int IN_SEL      = 4;
  localparam int AX_A        = 0;
  localparam int AX_B        = 1;

  typedef enum logic [1:0] {
    ST_TORQUE_OFF,
    ST_RUN,
    ST_STOP_DELAY
  } sto_state_t;

endpackage

// ### hw/sto_top.sv
// Two-axis safe-torque-off logic: shutdown inputs, release pulse, drive feedback,
// redundant shut-off outputs and auxiliary outputs per axis.
// Assumes all pin inputs are asynchronous contact levels, high meaning closed,
// and that each output high means its contact pair is closed.
//
// Overview of operation
// - Both shut-off channel outputs open in torque-off, closed only while released.
// - Second channel output always carries the first channel's state.
// - First auxiliary output follows the first channel.
// - Second auxiliary output matches the first auxiliary output.
// - Open drive feedback means drive shut off; closed means drive released.
// - Open first shutdown input demands torque-off; closed permits release.
// - Second shutdown input is treated exactly like the first.
// - Torque-off is left only on an on-to-off release pulse transition.
// - Feedback status output mirrors the drive feedback input directly.
// - Axis A stop delay selectable 0, 1.4, 2.8, 5.6, 9.8, 30.8 s.
// - Axis B stop delay selectable 0, 1.4, 2.8, 9.8, 30.8 s.
// - With zero delay, outputs open within 10 ms of the demand.
`timescale 1ns/100ps
module sto_top #(
  parameter logic [31:0] DLY_1P4_CYC  = sto_pkg::DLY_1P4_MS * sto_pkg::CYC_PER_MS,
  parameter logic [31:0] DLY_2P8_CYC  = sto_pkg::DLY_2P8_MS * sto_pkg::CYC_PER_MS,
  parameter logic [31:0] DLY_5P6_CYC  = sto_pkg::DLY_5P6_MS * sto_pkg::CYC_PER_MS,
  parameter logic [31:0] DLY_9P8_CYC  = sto_pkg::DLY_9P8_MS * sto_pkg::CYC_PER_MS,
  parameter logic [31:0] DLY_30P8_CYC = sto_pkg::DLY_30P8_MS * sto_pkg::CYC_PER_MS,
  parameter logic [31:0] DEB_CYC      = sto_pkg::DEB_MS * sto_pkg::CYC_PER_MS,
  parameter logic [31:0] DISC_CYC     = sto_pkg::DISC_MS * sto_pkg::CYC_PER_MS
) (
  input  wire logic       i_sys_clk,                     // System clock, 125 MHz.
  input  wire logic       i_rst_n,                       // Asynchronous reset, active low.
  input  wire logic       i_a_shutdown_in_one,           // Axis A shutdown 1, high closed.
  input  wire logic       i_a_shutdown_in_two,           // Axis A shutdown 2, high closed.
  input  wire logic       i_a_release_pulse_in,          // Axis A start/reset, high on.
  input  wire logic       i_a_drive_feedback_in,         // Axis A drive feedback, high closed.
  input  wire logic [2:0] i_a_delay_sel,                 // Axis A stop delay switch.
  input  wire logic       i_b_shutdown_in_one,           // Axis B shutdown 1, high closed.
  input  wire logic       i_b_shutdown_in_two,           // Axis B shutdown 2, high closed.
  input  wire logic       i_b_release_pulse_in,          // Axis B start/reset, high on.
  input  wire logic       i_b_drive_feedback_in,         // Axis B drive feedback, high closed.
  input  wire logic [2:0] i_b_delay_sel,                 // Axis B stop delay switch.
  output logic            o_a_torque_off_channel_one,    // Axis A channel 1, high closed.
  output logic            o_a_torque_off_channel_two,    // Axis A channel 2, high closed.
  output logic            o_a_aux_shutoff_out_one,       // Axis A auxiliary 1, high closed.
  output logic            o_a_aux_shutoff_out_two,       // Axis A auxiliary 2, high closed.
  output logic            o_a_feedback_status,           // Axis A feedback mirror.
  output logic            o_a_stop_pending,              // Axis A stop delay running.
  output logic            o_a_fault,                     // Axis A channel fault, sticky.
  output logic            o_b_torque_off_channel_one,    // Axis B channel 1, high closed.
  output logic            o_b_torque_off_channel_two,    // Axis B channel 2, high closed.
  output logic            o_b_aux_shutoff_out_one,       // Axis B auxiliary 1, high closed.
  output logic            o_b_aux_shutoff_out_two,       // Axis B auxiliary 2, high closed.
  output logic            o_b_feedback_status,           // Axis B feedback mirror.
  output logic            o_b_stop_pending,              // Axis B stop delay running.
  output logic            o_b_fault                      // Axis B channel fault, sticky.
);

  sto_filt_if filt_if ();

  logic [sto_pkg::N_AXIS-1:0] closed_q;
  logic [sto_pkg::N_AXIS-1:0] pending_q;
  logic [sto_pkg::N_AXIS-1:0] fault_q;

  // Delay cycles for a switch code. An unknown code, or the 5.6 s code on
  // axis B, selects no delay: stopping at once is the safe reading.
  function automatic logic [31:0] stop_delay(input logic is_b, input logic [2:0] sel);
    case (sel)
      sto_pkg::SEL_1P4:  stop_delay = DLY_1P4_CYC;
      sto_pkg::SEL_2P8:  stop_delay = DLY_2P8_CYC;
      sto_pkg::SEL_5P6:  stop_delay = is_b ? 32'h0 : DLY_5P6_CYC;
      sto_pkg::SEL_9P8:  stop_delay = DLY_9P8_CYC;
      sto_pkg::SEL_30P8: stop_delay = DLY_30P8_CYC;
      default:           stop_delay = 32'h0;
    endcase
  endfunction

  assign filt_if.raw = {i_b_delay_sel, i_b_drive_feedback_in, i_b_release_pulse_in,
                        i_b_shutdown_in_two, i_b_shutdown_in_one,
                        i_a_delay_sel, i_a_drive_feedback_in, i_a_release_pulse_in,
                        i_a_shutdown_in_two, i_a_shutdown_in_one};

  sto_in_filter #(
    .DEB_CYC (sto_pkg::DEB_W'(DEB_CYC))
  ) u_filter (
    .i_sys_clk (i_sys_clk),
    .i_rst_n   (i_rst_n),
    .f         (filt_if.filt)
  );

  for (genvar ax = 0; ax < sto_pkg::N_AXIS; ax++) begin : g_axis
    localparam int BASE = ax * sto_pkg::IN_PER_AXIS;

    sto_pkg::sto_state_t           state_q;
    logic [sto_pkg::CNT_W-1:0]     dly_q;
    logic [sto_pkg::CNT_W-1:0]     disc_q;
    logic                          rel_prev_q;
    logic                          sd1;
    logic                          sd2;
    logic                          rel;
    logic                          fb_closed;
    logic [2:0]                    sel;
    logic                          demand;
    logic                          rel_edge;
    logic                          disc_hit;
    logic [31:0]                   dly_sel;

    assign sd1       = filt_if.clean[BASE + sto_pkg::IN_SD1];
    assign sd2       = filt_if.clean[BASE + sto_pkg::IN_SD2];
    assign rel       = filt_if.clean[BASE + sto_pkg::IN_REL];
    assign fb_closed = filt_if.clean[BASE + sto_pkg::IN_FB];
    assign sel       = filt_if.clean[BASE + sto_pkg::IN_SEL +: 3];

    // open second input does the same.
    assign demand   = !sd1 || !sd2;
    assign rel_edge = rel_prev_q && !rel;
    // axis B has no 5.6 s choice.
    assign dly_sel  = stop_delay(ax == sto_pkg::AX_B, sel);
    // the switch must keep both channels alike; a lasting mismatch is a fault.
    assign disc_hit = (sd1 != sd2) && (disc_q == DISC_CYC - 1'b1);

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
        rel_prev_q <= 1'b0;
      end else begin
        rel_prev_q <= rel;
      end
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
        disc_q <= '0;
      end else if (sd1 == sd2 || disc_hit) begin
        disc_q <= '0;
      end else begin
        disc_q <= disc_q + 1'b1;
      end
    end

    // sticky fault, set wins over clear.
    // A release pulse with both channels agreeing clears it.
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
        fault_q[ax] <= 1'b0;
      end else if (disc_hit) begin
        fault_q[ax] <= 1'b1;
      end else if (rel_edge && sd1 == sd2) begin
        fault_q[ax] <= 1'b0;
      end
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
        state_q <= sto_pkg::ST_TORQUE_OFF;
        dly_q   <= '0;
      end else begin
        case (state_q)
          sto_pkg::ST_TORQUE_OFF: begin
            // leave torque-off only on the release edge.
            // and only while the drive reports itself shut off.
            if (rel_edge && !demand && !fault_q[ax] && !fb_closed) begin
              state_q <= sto_pkg::ST_RUN;
            end
          end
          sto_pkg::ST_RUN: begin
            // zero delay goes straight to torque-off.
            if (fault_q[ax] || (demand && dly_sel == 32'h0)) begin
              state_q <= sto_pkg::ST_TORQUE_OFF;
            end else if (demand) begin
              state_q <= sto_pkg::ST_STOP_DELAY;
              dly_q   <= dly_sel - 1'b1;
            end
          end
          sto_pkg::ST_STOP_DELAY: begin
            // count out the selected stop delay.
            if (fault_q[ax] || dly_q == '0) begin
              state_q <= sto_pkg::ST_TORQUE_OFF;
            end else begin
              dly_q <= dly_q - 1'b1;
            end
          end
          default: begin
            state_q <= sto_pkg::ST_TORQUE_OFF;
          end
        endcase
      end
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
        closed_q[ax]  <= 1'b0;
        pending_q[ax] <= 1'b0;
      end else begin
        closed_q[ax]  <= state_q != sto_pkg::ST_TORQUE_OFF;
        pending_q[ax] <= state_q == sto_pkg::ST_STOP_DELAY;
      end
    end
  end

  // channel two is a copy of channel one.
  assign o_a_torque_off_channel_one = closed_q[sto_pkg::AX_A];
  assign o_a_torque_off_channel_two = closed_q[sto_pkg::AX_A];
  assign o_a_aux_shutoff_out_one    = closed_q[sto_pkg::AX_A];
  assign o_a_aux_shutoff_out_two    = closed_q[sto_pkg::AX_A];
  assign o_b_torque_off_channel_one = closed_q[sto_pkg::AX_B];
  assign o_b_torque_off_channel_two = closed_q[sto_pkg::AX_B];
  assign o_b_aux_shutoff_out_one    = closed_q[sto_pkg::AX_B];
  assign o_b_aux_shutoff_out_two    = closed_q[sto_pkg::AX_B];
  assign o_a_stop_pending           = pending_q[sto_pkg::AX_A];
  assign o_b_stop_pending           = pending_q[sto_pkg::AX_B];
  assign o_a_fault                  = fault_q[sto_pkg::AX_A];
  assign o_b_fault                  = fault_q[sto_pkg::AX_B];

  // the status pin is wired straight from the feedback pin, like a
  // plain connection, so it shows the drive even while the unit is in reset.
  assign o_a_feedback_status = i_a_drive_feedback_in;
  assign o_b_feedback_status = i_b_drive_feedback_in;

endmodule

// ### testbench/sto_drive_model.sv
// Power stage of one axis: feedback closes some cycles after both channels close.
// Assumes LAT of two or more; i_stuck models a stage that fails to shut off.
`timescale 1ns/100ps
module sto_drive_model #(
  parameter int LAT = 2
) (
  input  wire logic i_sys_clk,  // Clock.
  input  wire logic i_rst_n,    // Reset, active low.
  input  wire logic i_ch_one,   // Channel one, high closed.
  input  wire logic i_ch_two,   // Channel two, high closed.
  input  wire logic i_stuck,    // Stage stuck on.
  output logic      o_feedback  // Feedback, high closed.
);
  logic [LAT-1:0] pipe_q;
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pipe_q <= '0;
    end else begin
      pipe_q <= {pipe_q[LAT-2:0], i_ch_one & i_ch_two};
    end
  end
  assign o_feedback = pipe_q[LAT-1] | i_stuck;
endmodule

// ### testbench/sto_sva.sv
// Port checks for the torque-off unit: axis A in full, axis B channel pairing.
// Assumes each delay switch holds still through a whole stop sequence.
`timescale 1ns/100ps
module sto_sva #(
  parameter logic [31:0] DLY_1P4_CYC  = 32'h14,
  parameter logic [31:0] DLY_2P8_CYC  = 32'h28,
  parameter logic [31:0] DLY_5P6_CYC  = 32'h50,
  parameter logic [31:0] DLY_9P8_CYC  = 32'h8c,
  parameter logic [31:0] DLY_30P8_CYC = 32'h1b8
) (
  input wire logic       i_sys_clk,                  // Clock.
  input wire logic       i_rst_n,                    // Reset, active low.
  input wire logic       i_a_shutdown_in_one,        // Shutdown pin one.
  input wire logic       i_a_shutdown_in_two,        // Shutdown pin two.
  input wire logic       i_a_release_pulse_in,       // Release pin.
  input wire logic       i_a_drive_feedback_in,      // Feedback pin.
  input wire logic [2:0] i_a_delay_sel,              // Delay switch.
  input wire logic       o_a_torque_off_channel_one, // Channel one.
  input wire logic       o_a_torque_off_channel_two, // Channel two.
  input wire logic       o_a_aux_shutoff_out_one,    // Auxiliary one.
  input wire logic       o_a_aux_shutoff_out_two,    // Auxiliary two.
  input wire logic       o_a_feedback_status,        // Feedback mirror.
  input wire logic       o_a_stop_pending,           // Delay running.
  input wire logic       o_a_fault,                  // Channel fault.
  input wire logic       o_b_torque_off_channel_one, // Axis B channel one.
  input wire logic       o_b_torque_off_channel_two  // Axis B channel two.
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);
  logic [31:0] pend_q;
  logic [31:0] want;
  // Counts the cycles the stop delay has run so its length can be judged at the end.
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pend_q <= 32'h0;
    end else begin
      pend_q <= o_a_stop_pending ? pend_q + 32'h1 : 32'h0;
    end
  end
  always_comb begin
    case (i_a_delay_sel)
      3'h1: want = DLY_1P4_CYC;
      3'h2: want = DLY_2P8_CYC;
      3'h3: want = DLY_5P6_CYC;
      3'h4: want = DLY_9P8_CYC;
      3'h5: want = DLY_30P8_CYC;
      default: want = 32'h0;
    endcase
  end
  sequence s_demand;
    $fell(i_a_shutdown_in_one & i_a_shutdown_in_two) && (i_a_delay_sel == 3'h0);
  endsequence
  sequence s_open_soon;
    ##[1:16] !o_a_torque_off_channel_one;
  endsequence
  pair_chan_a: assert property (o_a_torque_off_channel_two == o_a_torque_off_channel_one &&
    o_b_torque_off_channel_two == o_b_torque_off_channel_one)
    else $error("channel two differs from channel one");
  aux_follow_a: assert property (o_a_aux_shutoff_out_one == o_a_torque_off_channel_one)
    else $error("auxiliary one differs from channel one");
  aux_match_a: assert property (o_a_aux_shutoff_out_two == o_a_aux_shutoff_out_one)
    else $error("auxiliary two differs from auxiliary one");
  fb_mirror_a: assert property (o_a_feedback_status == i_a_drive_feedback_in)
    else $error("feedback status differs from feedback pin");
  release_edge_a: assert property ($rose(o_a_torque_off_channel_one) |-> !i_a_release_pulse_in)
    else $error("channels closed while release pin on");
  permit_only_a: assert property ($rose(o_a_torque_off_channel_one) |->
    i_a_shutdown_in_one && i_a_shutdown_in_two) else $error("channels closed under demand");
  drive_off_a: assert property ($rose(o_a_torque_off_channel_one) |-> !i_a_drive_feedback_in)
    else $error("channels closed while drive feedback closed");
  fast_stop_a: assert property (s_demand |-> s_open_soon)
    else $error("zero delay stop too slow");
  pend_closed_a: assert property (o_a_stop_pending |-> o_a_torque_off_channel_one)
    else $error("channels open while delay runs");
  delay_len_a: assert property ($fell(o_a_stop_pending) && !o_a_fault |->
    pend_q + 32'h1 >= want && pend_q <= want + 32'h1) else $error("stop delay length wrong");
  fault_cause_a: assert property ($rose(o_a_fault) |->
    (i_a_shutdown_in_one != i_a_shutdown_in_two) ##[0:2] !o_a_torque_off_channel_one)
    else $error("fault without disagreement or channels left closed");
  cover property (o_a_stop_pending ##1 !o_a_stop_pending);
endmodule

// ### testbench/tb.sv
// Self-checking bench: both axes with a power stage model each, shortened counts.
// Assumes debounce of 4 cycles and the delay counts set below.
`timescale 1ns/100ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin n_mismatch++; \
  $display("mismatch %s exp %0h got %0h", nm, e, g); end end
bind sto_top sto_sva #(.DLY_1P4_CYC(DLY_1P4_CYC), .DLY_2P8_CYC(DLY_2P8_CYC),
  .DLY_5P6_CYC(DLY_5P6_CYC), .DLY_9P8_CYC(DLY_9P8_CYC), .DLY_30P8_CYC(DLY_30P8_CYC))
  sto_sva_inst (.i_sys_clk, .i_rst_n, .i_a_shutdown_in_one, .i_a_shutdown_in_two,
  .i_a_release_pulse_in, .i_a_drive_feedback_in, .i_a_delay_sel, .o_a_torque_off_channel_one,
  .o_a_torque_off_channel_two, .o_a_aux_shutoff_out_one, .o_a_aux_shutoff_out_two,
  .o_a_feedback_status, .o_a_stop_pending, .o_a_fault, .o_b_torque_off_channel_one,
  .o_b_torque_off_channel_two);
module tb;
  localparam logic [31:0] D [5] = '{32'h14, 32'h28, 32'h50, 32'h8c, 32'h1b8};
  logic       clk;
  logic       rst_n;
  logic [1:0] sd1, sd2, rel, stuck;
  logic [2:0] sel [2];
  wire  [1:0] fb, ch1, ch2, ax1, ax2, fbs, pend, flt;
  int         n_mismatch, n_compared;
  sto_top #(.DLY_1P4_CYC(D[0]), .DLY_2P8_CYC(D[1]), .DLY_5P6_CYC(D[2]), .DLY_9P8_CYC(D[3]),
    .DLY_30P8_CYC(D[4]), .DEB_CYC(32'h4), .DISC_CYC(32'h32)) sto_top_inst (
    .i_sys_clk(clk), .i_rst_n(rst_n), .i_a_shutdown_in_one(sd1[0]),
    .i_a_shutdown_in_two(sd2[0]), .i_a_release_pulse_in(rel[0]), .i_a_drive_feedback_in(fb[0]),
    .i_a_delay_sel(sel[0]), .i_b_shutdown_in_one(sd1[1]), .i_b_shutdown_in_two(sd2[1]),
    .i_b_release_pulse_in(rel[1]), .i_b_drive_feedback_in(fb[1]), .i_b_delay_sel(sel[1]),
    .o_a_torque_off_channel_one(ch1[0]), .o_a_torque_off_channel_two(ch2[0]),
    .o_a_aux_shutoff_out_one(ax1[0]), .o_a_aux_shutoff_out_two(ax2[0]),
    .o_a_feedback_status(fbs[0]), .o_a_stop_pending(pend[0]), .o_a_fault(flt[0]),
    .o_b_torque_off_channel_one(ch1[1]), .o_b_torque_off_channel_two(ch2[1]),
    .o_b_aux_shutoff_out_one(ax1[1]), .o_b_aux_shutoff_out_two(ax2[1]),
    .o_b_feedback_status(fbs[1]), .o_b_stop_pending(pend[1]), .o_b_fault(flt[1]));
  for (genvar g = 0; g < 2; g++) begin : g_drv
    sto_drive_model #(.LAT(2 + 4 * g)) sto_drive_model_inst (.i_sys_clk(clk), .i_rst_n(rst_n),
      .i_ch_one(ch1[g]), .i_ch_two(ch2[g]), .i_stuck(stuck[g]), .o_feedback(fb[g]));
  end
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic conclude;
    $display("mismatches %0d compared %0d", n_mismatch, n_compared);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  function automatic logic [31:0] exp_dly(input int ax, input logic [2:0] s);
    if (s == 3'h0 || s > 3'h5 || (ax == 1 && s == 3'h3)) return 32'h0;
    return D[s - 3'h1];
  endfunction
  // An on-to-off release pulse; the on phase alone must not close anything.
  task automatic press(input int ax, input logic exp);
    rel[ax] <= 1'b1;
    tick(12);
    `CHK("closed while on", 1'b0, ch1[ax])
    rel[ax] <= 1'b0;
    tick(12);
    `CHK("four outputs", {4{exp}}, {ch1[ax], ch2[ax], ax1[ax], ax2[ax]})
  endtask
  task automatic t_stop(input int ax, input logic [2:0] s);
    logic [31:0] d;
    d = exp_dly(ax, s);
    sel[ax] <= s;
    tick(12);
    sd1[ax] <= 1'b0;
    sd2[ax] <= 1'b0;
    if (d > 0) begin
      tick(d);
      `CHK("closed in delay", 1'b1, ch1[ax] & pend[ax])
    end
    tick(d > 0 ? 20 : 16);
    `CHK("open after delay", 2'h0, {ch1[ax], pend[ax]})
    sd1[ax] <= 1'b1;
    sd2[ax] <= 1'b1;
    tick(12);
    press(ax, 1'b1);
  endtask
  task automatic t_refuse(input int ax);
    sd2[ax] <= 1'b0;
    tick(20);
    `CHK("second input demand", 2'h0, {ch1[ax], flt[ax]})
    press(ax, 1'b0);
    sd2[ax] <= 1'b1;
    stuck[ax] <= 1'b1;
    tick(12);
    `CHK("feedback mirror", 1'b1, fbs[ax])
    press(ax, 1'b0);
    stuck[ax] <= 1'b0;
    tick(12);
    `CHK("feedback mirror off", 1'b0, fbs[ax])
    press(ax, 1'b1);
  endtask
  // A reset in mid-run opens every channel at once, and a new release is needed after it.
  task automatic t_reset;
    rst_n <= 1'b0;
    tick(2);
    `CHK("open in mid-run reset", 8'h0, {ch1, ch2, ax1, ax2})
    rst_n <= 1'b1;
    tick(12);
    `CHK("open after reset", 8'h0, {ch1, ch2, ax1, ax2})
    press(0, 1'b1);
    press(1, 1'b1);
  endtask
  task automatic t_fault(input int ax);
    sd1[ax] <= 1'b0;
    tick(80);
    `CHK("fault set", 2'h2, {flt[ax], ch1[ax]})
    sd1[ax] <= 1'b1;
    tick(12);
    press(ax, 1'b0);
    `CHK("fault cleared", 1'b0, flt[ax])
    press(ax, 1'b1);
  endtask
  initial begin
    rst_n = 1'b0;
    {sd1, sd2, rel, stuck} = 8'hf0;
    sel[0] = 3'h0;
    sel[1] = 3'h0;
    n_mismatch = 0;
    n_compared = 0;
    tick(16);
    `CHK("open in reset", 8'h0, {ch1, ch2, ax1, ax2})
    rst_n <= 1'b1;
    tick(12);
    for (int ax = 0; ax < 2; ax++) begin
      press(ax, 1'b1);
      for (int s = 0; s < 8; s++) t_stop(ax, 3'(s));
      sel[ax] <= 3'h0;
      tick(12);
      t_refuse(ax);
      t_fault(ax);
    end
    t_reset();
    conclude();
  end
  initial begin
    tick(30000);
    n_mismatch++;
    conclude();
  end
endmodule
